//--- ebpt_top.sv
// five 8-bit period timers behind an AXI4-Lite register slave
// What this block does
// (RULE1) no timer counts while the core sleeps; counting happens only when awake.
// (RULE2) during sleep every count and period register keeps its value unchanged.
// (RULE3) control bit 7 does nothing, ignores writes and reads back as zero.
// (RULE4) control bits 6..3 give one postscaler output per value+1 matches, 1:1 to 1:16.
// (RULE5) control bit 2 is the run switch: one counts, zero stops.
// (RULE6) control bits 1..0 divide the input clock by 1, 4, 16 or 64.
// (RULE7) all writable control fields reset to zero on every reset.
// (RULE8) each timer's running count is an 8-bit register software reads and writes.
// (RULE9) each timer has its own addressable period register holding the match value.
// (RULE10) the count steps from 00h per tick, matches the period, pulses and restarts at 00h.
// (RULE11) reset clears the count and sets the period to all ones.
// (RULE12) reset, a count write and a control write clear both scalers; control writes keep the count.
// (RULE13) the postscaler end sets a latched flag, forwarded only when its enable is set.
// (RULE14) a set flag stays set until software clears it.
// (RULE15) with the run switch low counters hold and no match or flag is produced.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ebpt_map.svh"
module ebpt_top
    import ebpt_pkg::*;
(
    // clock, reset and enable
    input  logic                          aclk,
    input  logic                          aresetn,
    input  logic                          ce,
    // core power state
    input  logic                          sleep,
    // write address channel
    input  logic [`EBPT_ADDR_W-1:0]       s_axi_awaddr,
    input  logic                          s_axi_awvalid,
    output logic                          s_axi_awready,
    // write data channel
    input  logic [31:0]                   s_axi_wdata,
    input  logic [3:0]                    s_axi_wstrb,
    input  logic                          s_axi_wvalid,
    output logic                          s_axi_wready,
    // write response channel
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  logic                          s_axi_bready,
    // read address channel
    input  logic [`EBPT_ADDR_W-1:0]       s_axi_araddr,
    input  logic                          s_axi_arvalid,
    output logic                          s_axi_arready,
    // read data channel
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  logic                          s_axi_rready,
    // timer outputs
    output logic [`EBPT_NUM_TMR-1:0]      match_pulse,
    output logic [`EBPT_NUM_TMR-1:0]      irq_req
);
    localparam int NT = `EBPT_NUM_TMR;

    ebpt_top_s                 st_r;
    ebpt_top_s                 st_nxt;
    logic [5:0]                wdec;
    logic [5:0]                rdec;
    logic                      wr_fire;
    logic                      wsel_ok;
    logic [NT-1:0]             ctrl_wr;
    logic [NT-1:0]             cnt_wr;
    logic [NT-1:0]             per_wr;
    logic [NT-1:0]             irq_wr;
    logic [NT-1:0]             flag_clr;
    logic [NT-1:0]             run;
    logic [NT-1:0]             clr_sc;
    logic [NT-1:0]             tick;
    logic [NT-1:0]             post_done;
    logic [NT-1:0][7:0]        count_q;

    // address to {valid, timer, register}
    function automatic logic [5:0] ebpt_decode(input logic [`EBPT_ADDR_W-1:0] a);
        logic ok;
        ok = (a[11:7] == 5'h00) && (a[6:4] < 3'(NT)) && (a[1:0] == 2'h0);
        return {ok, a[6:4], a[3:2]};
    endfunction

    // register read mux
    function automatic logic [7:0] ebpt_read(input ebpt_top_s s,
                                             input logic [NT-1:0][7:0] cq,
                                             input logic [5:0] d);
        logic [7:0] v;
        v = 8'h00;
        if (d[5]) begin
            unique case (d[1:0])
                `EBPT_IDX_CTRL:   v = {1'b0, s.ctrl[d[4:2]]}; // [RULE3]
                `EBPT_IDX_PERIOD: v = s.period[d[4:2]]; // [RULE9]
                `EBPT_IDX_COUNT:  v = cq[d[4:2]]; // [RULE8]
                `EBPT_IDX_IRQ:    v = {6'h00, s.ien[d[4:2]], s.flag[d[4:2]]};
            endcase
        end
        return v;
    endfunction

    assign s_axi_awready = (st_r.wr_st == EBPT_W_IDLE) && !st_r.aw_got;
    assign s_axi_wready  = (st_r.wr_st == EBPT_W_IDLE) && !st_r.w_got;
    assign s_axi_bvalid  = (st_r.wr_st == EBPT_W_RESP);
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = (st_r.rd_st == EBPT_R_IDLE);
    assign s_axi_rvalid  = (st_r.rd_st == EBPT_R_RESP);
    assign s_axi_rdata   = {24'h000000, st_r.rdata};
    assign s_axi_rresp   = st_r.rresp;
    assign irq_req       = st_r.flag & st_r.ien; // [RULE13]

    assign wdec    = ebpt_decode(st_r.waddr);
    assign rdec    = ebpt_decode(s_axi_araddr);
    assign wr_fire = (st_r.wr_st == EBPT_W_IDLE) && st_r.aw_got && st_r.w_got;
    assign wsel_ok = wr_fire && wdec[5] && st_r.wlane0;

    // per-timer write strobes, sleep blocks count and period writes
    always_comb begin
        for (int i = 0; i < NT; i++) begin
            ctrl_wr[i]  = wsel_ok && (wdec[4:2] == 3'(i)) && (wdec[1:0] == `EBPT_IDX_CTRL);
            cnt_wr[i]   = wsel_ok && (wdec[4:2] == 3'(i)) && (wdec[1:0] == `EBPT_IDX_COUNT)
                          && !sleep; // [RULE2]
            per_wr[i]   = wsel_ok && (wdec[4:2] == 3'(i)) && (wdec[1:0] == `EBPT_IDX_PERIOD)
                          && !sleep; // [RULE2]
            irq_wr[i]   = wsel_ok && (wdec[4:2] == 3'(i)) && (wdec[1:0] == `EBPT_IDX_IRQ);
            flag_clr[i] = irq_wr[i] && st_r.wdata[`EBPT_IRQ_FLAG_BIT];
        end
    end

    always_comb begin
        st_nxt = st_r;
        // write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.wdata  = s_axi_wdata[7:0];
            st_nxt.wlane0 = s_axi_wstrb[0];
        end
        unique case (st_r.wr_st)
            EBPT_W_IDLE: begin
                if (wr_fire) begin
                    st_nxt.aw_got = 1'b0;
                    st_nxt.w_got  = 1'b0;
                    st_nxt.wr_st  = EBPT_W_RESP;
                    st_nxt.bresp  = wdec[5] ? `EBPT_RESP_OKAY : `EBPT_RESP_SLVERR;
                end
            end
            EBPT_W_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wr_st = EBPT_W_IDLE;
                end
            end
            default: st_nxt.wr_st = EBPT_W_IDLE;
        endcase
        // register updates
        for (int i = 0; i < NT; i++) begin
            if (ctrl_wr[i]) begin
                st_nxt.ctrl[i] = st_r.wdata[`EBPT_POST_MSB:0]; // [RULE3] [RULE4] [RULE5] [RULE6]
            end
            if (per_wr[i]) begin
                st_nxt.period[i] = st_r.wdata; // [RULE9]
            end
            if (irq_wr[i]) begin
                st_nxt.ien[i] = st_r.wdata[`EBPT_IRQ_EN_BIT];
            end
            st_nxt.flag[i] = (st_r.flag[i] & ~flag_clr[i]) | post_done[i]; // [RULE13] [RULE14]
        end
        // read channel
        unique case (st_r.rd_st)
            EBPT_R_IDLE: begin
                if (s_axi_arvalid) begin
                    st_nxt.rd_st = EBPT_R_RESP;
                    st_nxt.rdata = ebpt_read(st_r, count_q, rdec);
                    st_nxt.rresp = rdec[5] ? `EBPT_RESP_OKAY : `EBPT_RESP_SLVERR;
                end
            end
            EBPT_R_RESP: begin
                if (s_axi_rready) begin
                    st_nxt.rd_st = EBPT_R_IDLE;
                end
            end
            default: st_nxt.rd_st = EBPT_R_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.wr_st  <= EBPT_W_IDLE;
            st_r.rd_st  <= EBPT_R_IDLE;
            st_r.aw_got <= 1'b0;
            st_r.waddr  <= '0;
            st_r.w_got  <= 1'b0;
            st_r.wdata  <= 8'h00;
            st_r.wlane0 <= 1'b0;
            st_r.bresp  <= `EBPT_RESP_OKAY;
            st_r.rdata  <= 8'h00;
            st_r.rresp  <= `EBPT_RESP_OKAY;
            st_r.ctrl   <= {NT{`EBPT_CTRL_RST}}; // [RULE7]
            st_r.period <= {NT{`EBPT_PERIOD_RST}}; // [RULE11]
            st_r.flag   <= '0;
            st_r.ien    <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // timer instances
    for (genvar g = 0; g < NT; g++) begin : g_tmr
        assign run[g]    = st_r.ctrl[g][`EBPT_RUN_BIT] && !sleep; // [RULE1] [RULE5]
        assign clr_sc[g] = ctrl_wr[g] || cnt_wr[g]; // [RULE12]

        ebpt_prescaler u_pre (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ce      (ce),
            .run     (run[g]),
            .clr     (clr_sc[g]),
            .ratio   (st_r.ctrl[g][`EBPT_PRE_MSB:`EBPT_PRE_LSB]),
            .tick    (tick[g])
        );

        ebpt_timer u_tmr (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .ce         (ce),
            .run        (run[g]),
            .tick       (tick[g]),
            .clr        (clr_sc[g]),
            .post_ratio (st_r.ctrl[g][`EBPT_POST_MSB:`EBPT_POST_LSB]),
            .period     (st_r.period[g]),
            .cnt_wr     (cnt_wr[g]),
            .cnt_wdata  (st_r.wdata),
            .count      (count_q[g]),
            .match      (match_pulse[g]),
            .post_done  (post_done[g])
        );
    end

    a_sleep_regs_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
        (ce && sleep) |=> ($stable(count_q) && $stable(st_r.period)))
        else $error("count or period changed during sleep");
    a_sleep_no_match: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
        (sleep && $past(sleep)) |-> (match_pulse == '0))
        else $error("timer matched during sleep");
    a_ctrl_msb_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
        (ce && s_axi_arvalid && s_axi_arready && rdec[5] && rdec[1:0] == `EBPT_IDX_CTRL)
        |=> (s_axi_rvalid && s_axi_rdata[7:0] == {1'b0, $past(st_r.ctrl[rdec[4:2]])}))
        else $error("control read back wrong");
    a_reset_values: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
        $rose(aresetn) |-> (st_r.ctrl == '0 && st_r.period == {NT{`EBPT_PERIOD_RST}}
                            && count_q == '0))
        else $error("reset values wrong");
    a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
        (ce && post_done != '0) |=> ((st_r.flag & $past(post_done)) == $past(post_done)))
        else $error("postscaler event lost");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE14]
        ce |=> ((~st_r.flag & $past(st_r.flag) & ~$past(flag_clr)) == '0))
        else $error("flag cleared without software");
    a_ctrl_keeps_count: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
        (ce && ctrl_wr != '0 && run == '0) |=> $stable(count_q))
        else $error("control write changed count");
    a_write_resp_next: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && wr_fire) |=> (s_axi_bvalid && s_axi_bresp == $past(wdec[5] ? 2'h0 : 2'h2)))
        else $error("write response missing");
endmodule

//--- ebpt_map.svh
// register map, field positions, reset values and scaler counts of the period timer
`ifndef EBPT_MAP_SVH
`define EBPT_MAP_SVH

`define EBPT_NUM_TMR      5
`define EBPT_ADDR_W       12

// per-timer register index, byte address = timer*16 + index*4
`define EBPT_IDX_CTRL     2'h0
`define EBPT_IDX_PERIOD   2'h1
`define EBPT_IDX_COUNT    2'h2
`define EBPT_IDX_IRQ      2'h3

// control fields
`define EBPT_CTRL_MSB     7
`define EBPT_POST_MSB     6
`define EBPT_POST_LSB     3
`define EBPT_RUN_BIT      2
`define EBPT_PRE_MSB      1
`define EBPT_PRE_LSB      0

// irq register fields
`define EBPT_IRQ_FLAG_BIT 0
`define EBPT_IRQ_EN_BIT   1

// reset values
`define EBPT_CTRL_RST     7'h00
`define EBPT_PERIOD_RST   8'hFF
`define EBPT_COUNT_RST    8'h00

// prescaler terminal counts for 1, 4, 16, 64
`define EBPT_PRE_TC1      6'h00
`define EBPT_PRE_TC4      6'h03
`define EBPT_PRE_TC16     6'h0F
`define EBPT_PRE_TC64     6'h3F

// bus responses
`define EBPT_RESP_OKAY    2'h0
`define EBPT_RESP_SLVERR  2'h2

`endif

//--- ebpt_pkg.sv
// types shared by the period timer modules
package ebpt_pkg;
`include "ebpt_map.svh"

    typedef enum logic [1:0] {EBPT_W_IDLE = 2'b01, EBPT_W_RESP = 2'b10} ebpt_wr_e;
    typedef enum logic [1:0] {EBPT_R_IDLE = 2'b01, EBPT_R_RESP = 2'b10} ebpt_rd_e;

    typedef struct packed {
        logic [5:0] cnt;
    } ebpt_pre_s;

    typedef struct packed {
        logic [7:0] count;
        logic [3:0] post;
        logic       match;
        logic       post_done;
    } ebpt_tmr_s;

    typedef struct packed {
        ebpt_wr_e                             wr_st;
        ebpt_rd_e                             rd_st;
        logic                                 aw_got;
        logic [`EBPT_ADDR_W-1:0]              waddr;
        logic                                 w_got;
        logic [7:0]                           wdata;
        logic                                 wlane0;
        logic [1:0]                           bresp;
        logic [7:0]                           rdata;
        logic [1:0]                           rresp;
        logic [`EBPT_NUM_TMR-1:0][6:0]        ctrl;
        logic [`EBPT_NUM_TMR-1:0][7:0]        period;
        logic [`EBPT_NUM_TMR-1:0]             flag;
        logic [`EBPT_NUM_TMR-1:0]             ien;
    } ebpt_top_s;

    // prescale code to terminal count
    function automatic logic [5:0] ebpt_pre_limit(input logic [1:0] code);
        logic [5:0] tc;
        tc = `EBPT_PRE_TC1;
        unique case (code)
            2'h0: tc = `EBPT_PRE_TC1;
            2'h1: tc = `EBPT_PRE_TC4;
            2'h2: tc = `EBPT_PRE_TC16;
            2'h3: tc = `EBPT_PRE_TC64;
        endcase
        return tc;
    endfunction
endpackage

//--- ebpt_prescaler.sv
// clock prescaler of one period timer
`timescale 1ns/1ps
`include "ebpt_map.svh"
module ebpt_prescaler
    import ebpt_pkg::*;
(
    // clock and reset
    input  logic       aclk,
    input  logic       aresetn,
    input  logic       ce,
    // control
    input  logic       run,
    input  logic       clr,
    input  logic [1:0] ratio,
    // prescaled tick
    output logic       tick
);
    ebpt_pre_s st_r;
    ebpt_pre_s st_nxt;

    assign tick = run && (st_r.cnt == ebpt_pre_limit(ratio)); // [RULE6]

    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.cnt = 6'h00; // [RULE12]
        end else if (run) begin
            st_nxt.cnt = tick ? 6'h00 : 6'(st_r.cnt + 6'h01); // [RULE6] [RULE15]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.cnt <= 6'h00;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    a_pre_clear_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
        (ce && clr) |=> (st_r.cnt == 6'h00))
        else $error("prescaler not cleared by write");
    a_pre_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
        (ce && !run && !clr) |=> $stable(st_r.cnt))
        else $error("prescaler moved while stopped");
endmodule

//--- ebpt_timer.sv
// count, period compare and postscaler of one period timer
`timescale 1ns/1ps
`include "ebpt_map.svh"
module ebpt_timer
    import ebpt_pkg::*;
(
    // clock and reset
    input  logic       aclk,
    input  logic       aresetn,
    input  logic       ce,
    // control
    input  logic       run,
    input  logic       tick,
    input  logic       clr,
    input  logic [3:0] post_ratio,
    input  logic [7:0] period,
    // count write
    input  logic       cnt_wr,
    input  logic [7:0] cnt_wdata,
    // status
    output logic [7:0] count,
    output logic       match,
    output logic       post_done
);
    ebpt_tmr_s st_r;
    ebpt_tmr_s st_nxt;
    logic      hit;

    assign hit       = run && tick && !cnt_wr && (st_r.count == period); // [RULE10]
    assign count     = st_r.count;
    assign match     = st_r.match;
    assign post_done = st_r.post_done;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.match     = 1'b0;
        st_nxt.post_done = 1'b0;
        if (cnt_wr) begin
            st_nxt.count = cnt_wdata; // [RULE8]
        end else if (hit) begin
            st_nxt.count = 8'h00; // [RULE10]
            st_nxt.match = 1'b1;
        end else if (run && tick) begin
            st_nxt.count = 8'(st_r.count + 8'h01); // [RULE10]
        end
        if (clr) begin
            st_nxt.post = 4'h0; // [RULE12]
        end else if (hit) begin
            if (st_r.post == post_ratio) begin
                st_nxt.post      = 4'h0; // [RULE4]
                st_nxt.post_done = 1'b1; // [RULE13]
            end else begin
                st_nxt.post = 4'(st_r.post + 4'h1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.count     <= `EBPT_COUNT_RST; // [RULE11]
            st_r.post      <= 4'h0;
            st_r.match     <= 1'b0;
            st_r.post_done <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    a_match_wraps_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
        (ce && run && tick && !cnt_wr && st_r.count == period) |=> (match && count == 8'h00))
        else $error("match did not restart the count");
    a_stopped_no_event: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
        (ce && !run && !cnt_wr) |=> ($stable(st_r.count) && !match && !post_done))
        else $error("stopped timer changed or fired");
    a_post_ratio_end: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
        (ce && hit && !clr && st_r.post == post_ratio) |=> (post_done && st_r.post == 4'h0))
        else $error("postscaler missed its terminal count");
endmodule

//--- testbench.sv
// self-checking bench for the five period timers behind the register bus
`timescale 1ns/1ps
`include "ebpt_map.svh"
module testbench;
    import ebpt_pkg::*;

    logic                    aclk;
    logic                    aresetn;
    logic                    ce;
    logic                    sleep;
    logic [`EBPT_ADDR_W-1:0] s_axi_awaddr;
    logic                    s_axi_awvalid;
    logic                    s_axi_awready;
    logic [31:0]             s_axi_wdata;
    logic [3:0]              s_axi_wstrb;
    logic                    s_axi_wvalid;
    logic                    s_axi_wready;
    logic [1:0]              s_axi_bresp;
    logic                    s_axi_bvalid;
    logic                    s_axi_bready;
    logic [`EBPT_ADDR_W-1:0] s_axi_araddr;
    logic                    s_axi_arvalid;
    logic                    s_axi_arready;
    logic [31:0]             s_axi_rdata;
    logic [1:0]              s_axi_rresp;
    logic                    s_axi_rvalid;
    logic                    s_axi_rready;
    logic [4:0]              match_pulse;
    logic [4:0]              irq_req;
    logic [33:0]             rq[$];
    logic [1:0]              bq[$];
    int                      bad_count;
    int                      tests_run;
    int                      t;
    int                      n;
    logic [7:0]              pv[5];
    logic [7:0]              v;
    logic [7:0]              p;

    ebpt_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sleep(sleep),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .match_pulse(match_pulse), .irq_req(irq_req));

    always #50 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [11:0] ad(input int tm, input logic [1:0] i);
        return 12'(tm * 16) + {8'h00, i, 2'h0};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic b_d;
        bq.push_back(er);
        b_d = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= {24'($urandom()), d};
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!b_d) begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                s_axi_bready <= 1'h0;
                b_d = 1'h1;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic r_d;
        rq.push_back({er, 24'h000000, d});
        r_d = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!r_d) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                s_axi_rready <= 1'h0;
                r_d = 1'h1;
            end
        end
    endtask

    // cycles from one match pulse of a timer to the next
    task automatic gap(input int tm, output int c);
        do @(posedge aclk); while (match_pulse[tm] !== 1'h1);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (match_pulse[tm] !== 1'h1);
    endtask

    // count match pulses of a timer over a span of cycles
    task automatic quiet(input int tm, input int span, output int c);
        c = 0;
        repeat (span) begin
            @(posedge aclk);
            if (match_pulse[tm] === 1'h1) c++;
        end
    endtask

    // response monitor: oldest note against each answer
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1 && rq.size() > 0) begin
            chk("rdata", {8'h00, rq[0][23:0]}, s_axi_rdata);
            chk("rresp", {30'h00000000, rq[0][33:32]}, {30'h00000000, s_axi_rresp});
            void'(rq.pop_front());
        end
        if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1 && bq.size() > 0) begin
            chk("bresp", {30'h00000000, bq.pop_front()}, {30'h00000000, s_axi_bresp});
        end
    end

    initial begin
        #(100 * 60000);
        bad_count++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        ce = 1'h1;
        sleep = 1'h0;
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(32'hA0EC6E4A));
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (t = 0; t < 5; t++) begin
            rd(ad(t, `EBPT_IDX_CTRL), 8'h00, `EBPT_RESP_OKAY);
            rd(ad(t, `EBPT_IDX_PERIOD), 8'hFF, `EBPT_RESP_OKAY);
            rd(ad(t, `EBPT_IDX_COUNT), 8'h00, `EBPT_RESP_OKAY);
            rd(ad(t, `EBPT_IDX_IRQ), 8'h00, `EBPT_RESP_OKAY);
        end
        rd(12'h050, 8'h00, `EBPT_RESP_SLVERR);
        wr(12'h050, 8'h5A, `EBPT_RESP_SLVERR);
        $display("test reset_values done");
        for (t = 0; t < 5; t++) begin
            pv[t] = 8'($urandom());
            wr(ad(t, `EBPT_IDX_CTRL), 8'hFB, `EBPT_RESP_OKAY);
            wr(ad(t, `EBPT_IDX_PERIOD), pv[t], `EBPT_RESP_OKAY);
            wr(ad(t, `EBPT_IDX_COUNT), ~pv[t], `EBPT_RESP_OKAY);
        end
        for (t = 0; t < 5; t++) begin
            rd(ad(t, `EBPT_IDX_CTRL), 8'h7B, `EBPT_RESP_OKAY);
            rd(ad(t, `EBPT_IDX_PERIOD), pv[t], `EBPT_RESP_OKAY);
            rd(ad(t, `EBPT_IDX_COUNT), ~pv[t], `EBPT_RESP_OKAY);
        end
        $display("test register_access done");
        t = $urandom_range(4, 0);
        p = 8'($urandom_range(3, 1));
        wr(ad(t, `EBPT_IDX_COUNT), 8'h00, `EBPT_RESP_OKAY);
        wr(ad(t, `EBPT_IDX_PERIOD), p, `EBPT_RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            wr(ad(t, `EBPT_IDX_CTRL), {6'h01, 2'(c)}, `EBPT_RESP_OKAY);
            gap(t, n);
            chk("match gap", (1 << (2 * c)) * (p + 1), n);
        end
        $display("test prescale done");
        p = 8'($urandom_range(9, 5));
        wr(ad(t, `EBPT_IDX_PERIOD), p, `EBPT_RESP_OKAY);
        for (int ps = 0; ps < 16; ps++) begin
            wr(ad(t, `EBPT_IDX_CTRL), 8'h00, `EBPT_RESP_OKAY);
            wr(ad(t, `EBPT_IDX_IRQ), 8'h03, `EBPT_RESP_OKAY);
            wr(ad(t, `EBPT_IDX_COUNT), 8'h00, `EBPT_RESP_OKAY);
            wr(ad(t, `EBPT_IDX_CTRL), {1'h0, 4'(ps), 3'h4}, `EBPT_RESP_OKAY);
            n = 0;
            do begin
                @(posedge aclk);
                if (match_pulse[t] === 1'h1) n++;
            end while (irq_req[t] !== 1'h1);
            chk("postscale matches", ps + 1, n);
        end
        wr(ad(t, `EBPT_IDX_CTRL), 8'h00, `EBPT_RESP_OKAY);
        repeat (20) @(posedge aclk);
        chk("irq held", 1, irq_req[t]);
        rd(ad(t, `EBPT_IDX_IRQ), 8'h03, `EBPT_RESP_OKAY);
        wr(ad(t, `EBPT_IDX_IRQ), 8'h00, `EBPT_RESP_OKAY);
        chk("irq masked", 0, irq_req[t]);
        rd(ad(t, `EBPT_IDX_IRQ), 8'h01, `EBPT_RESP_OKAY);
        wr(ad(t, `EBPT_IDX_IRQ), 8'h01, `EBPT_RESP_OKAY);
        rd(ad(t, `EBPT_IDX_IRQ), 8'h00, `EBPT_RESP_OKAY);
        $display("test postscale_flag done");
        v = 8'($urandom());
        wr(ad(t, `EBPT_IDX_COUNT), v, `EBPT_RESP_OKAY);
        quiet(t, 40, n);
        chk("pulses while off", 0, n);
        s_axi_wstrb <= 4'hE;
        wr(ad(t, `EBPT_IDX_COUNT), ~v, `EBPT_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(ad(t, `EBPT_IDX_COUNT), v, `EBPT_RESP_OKAY);
        $display("test stopped done");
        @(posedge aclk);
        sleep <= 1'h1;
        wr(ad(t, `EBPT_IDX_CTRL), 8'h04, `EBPT_RESP_OKAY);
        quiet(t, 30, n);
        chk("pulses in sleep", 0, n);
        wr(ad(t, `EBPT_IDX_COUNT), ~v, `EBPT_RESP_OKAY);
        wr(ad(t, `EBPT_IDX_PERIOD), ~p, `EBPT_RESP_OKAY);
        rd(ad(t, `EBPT_IDX_COUNT), v, `EBPT_RESP_OKAY);
        rd(ad(t, `EBPT_IDX_PERIOD), p, `EBPT_RESP_OKAY);
        @(posedge aclk);
        sleep <= 1'h0;
        gap(t, n);
        chk("gap after wake", p + 1, n);
        ce <= 1'h0;
        quiet(t, 20, n);
        chk("pulses with ce low", 0, n);
        ce <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (match_pulse[t] !== 1'h1);
        chk("gap after freeze", p + 1, n);
        $display("test sleep done");
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ad(t, `EBPT_IDX_CTRL), 8'h00, `EBPT_RESP_OKAY);
        rd(ad(t, `EBPT_IDX_PERIOD), 8'hFF, `EBPT_RESP_OKAY);
        $display("test reset_again done");
        give_verdict();
    end
endmodule
